// >>> design/opil_defines.svh
// Register offsets, reset values and timing counts for the operator panel lamp logic
`ifndef OPIL_DEFINES_SVH
`define OPIL_DEFINES_SVH
`define OPIL_OFS_CTRL      12'h000
`define OPIL_OFS_SRC       12'h004
`define OPIL_OFS_MINFREQ   12'h008
`define OPIL_OFS_FREQREF   12'h00c
`define OPIL_OFS_LAMPS     12'h010
`define OPIL_OFS_IRQ_STAT  12'h014
`define OPIL_OFS_IRQ_MASK  12'h018
`define OPIL_CTRL_RESET    32'h0000_0000
`define OPIL_SRC_RESET     32'h0000_0000
`define OPIL_MINFREQ_RESET 16'h0000
`define OPIL_FREQREF_RESET 16'h0000
`define OPIL_MASK_RESET    7'h00
`define OPIL_BLINK_HALF_MS 250
`define OPIL_CLK_MHZ       100
`define OPIL_BLINK_CYCLES  (`OPIL_BLINK_HALF_MS * 1000 * `OPIL_CLK_MHZ)
// CTRL bit positions
`define OPIL_CTRL_REMOTE   0
`define OPIL_CTRL_FWD      1
`define OPIL_CTRL_REV      2
`define OPIL_CTRL_FAULT    3
`define OPIL_CTRL_ALARM    4
`define OPIL_CTRL_STOPKEY  5
`define OPIL_CTRL_DSTATE   8
// Lamp bit positions in LAMPS and IRQ registers
`define OPIL_L_FWD   0
`define OPIL_L_REV   1
`define OPIL_L_ALM   2
`define OPIL_L_SEQ   3
`define OPIL_L_REF   4
`define OPIL_L_RUN   5
`define OPIL_L_STOP  6
`endif

// >>> design/opil_pkg.sv
// Types for the operator panel lamp logic
package opil_pkg;
  typedef enum logic [1:0] {
    OPIL_DRV_STOPPED = 2'h0,
    OPIL_DRV_RUNNING = 2'h1,
    OPIL_DRV_DECEL   = 2'h2
  } opil_drive_t;
  typedef enum logic [2:0] {
    OPIL_SRC_KEYPAD = 3'h0,
    OPIL_SRC_TERM   = 3'h1,
    OPIL_SRC_COMM   = 3'h2,
    OPIL_SRC_OPTION = 3'h3,
    OPIL_SRC_PULSE  = 3'h4
  } opil_src_t;
  typedef enum logic [1:0] {
    OPIL_LAMP_OFF   = 2'h0,
    OPIL_LAMP_ON    = 2'h1,
    OPIL_LAMP_BLINK = 2'h2
  } opil_lamp_t;
endpackage

// >>> design/opil_prescaler.sv
// Clock prescaler making the shared blink toggle
`timescale 1ns/10ps
module opil_prescaler #(
  parameter int HALF_CYCLES = 25000000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      blink_q
);
  localparam int CW = $clog2(HALF_CYCLES);
  logic [CW-1:0] cnt_q;

  if (HALF_CYCLES < 2) begin : g_bad_half
    $error("opil_prescaler: HALF_CYCLES must be at least 2");
  end

  // One toggle for every lamp keeps all blinking lamps in step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q   <= '0;
      blink_q <= 1'b0;
    end else if (cnt_q == CW'(HALF_CYCLES - 1)) begin
      cnt_q   <= '0;
      blink_q <= ~blink_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // opil_prescaler

// >>> design/opil_lamp_drv.sv
// One lamp driver: turns a lamp mode into a pin level
`timescale 1ns/10ps
module opil_lamp_drv (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  opil_pkg::opil_lamp_t mode,
  input  wire logic       blink,
  output logic            lamp_q
);
  import opil_pkg::*;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_q <= 1'b0;
    end else begin
      unique case (mode)
        OPIL_LAMP_ON:    lamp_q <= 1'b1;
        OPIL_LAMP_BLINK: lamp_q <= blink;
        default:         lamp_q <= 1'b0;
      endcase
    end
  end
endmodule // opil_lamp_drv

// >>> design/opil_top.sv
// Operator panel lamp decode with AHB-Lite register slave
// Operation
// - The forward lamp is lit while a forward run command is applied.
// - The reverse lamp is lit while a reverse run command is applied.
// - The alarm lamp is steady while a fault is present.
// - The alarm lamp flashes while a non-fault alarm is present.
// - The remote-sequence lamp is off in local mode and follows the run source in remote mode.
// - In remote mode the remote-sequence lamp is lit for run source 1, 2 or 3.
// - The remote-sequence lamp is off for run source 0 (keypad).
// - The remote-reference lamp is off in local mode and follows the reference source in remote mode.
// - In remote mode the remote-reference lamp is lit for reference source 1, 2, 3 or 4.
// - The remote-reference lamp is off for reference source 0 (keypad).
// - The run lamp is on while running, blinks while decelerating and is off while stopped.
// - The stop lamp is on while decelerating or stopped and off while running normally.
// - The stop lamp blinks while running with the reference below the minimum output frequency.
// - The stop lamp blinks while running in remote mode after the keypad stop key was pressed.
// - Local mode means keypad control; remote mode means the two source settings govern.
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`include "opil_defines.svh"
module opil_top #(
  parameter int BLINK_HALF_CYCLES = `OPIL_BLINK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             forward_lamp,
  output logic             reverse_lamp,
  output logic             alarm_lamp,
  output logic             remote_sequence_lamp,
  output logic             remote_reference_lamp,
  output logic             run_lamp,
  output logic             stop_lamp,
  output logic             irq
);
  import opil_pkg::*;

  if (BLINK_HALF_CYCLES < 2) begin : g_bad_blink
    $error("opil_top: BLINK_HALF_CYCLES must be at least 2");
  end

  logic [31:0] ctrl_q;
  logic [31:0] src_q;
  logic [15:0] min_freq_q;
  logic [15:0] freq_ref_q;
  logic [6:0]  irq_stat_q;
  logic [6:0]  irq_mask_q;
  logic [6:0]  lamps;
  logic [6:0]  lamps_prev_q;
  logic        blink;
  logic        stop_key_q;
  logic        rst_seen_q;
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        rd_stat;
  logic [31:0] rdata_d;

  // Bus data phase: zero wait states, always OKAY
  wire         req      = hsel && hready && htrans[1];
  wire         wr_req   = req && hwrite;
  wire         rd_req   = req && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= wr_req;
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q     <= `OPIL_CTRL_RESET;
      src_q      <= `OPIL_SRC_RESET;
      min_freq_q <= `OPIL_MINFREQ_RESET;
      freq_ref_q <= `OPIL_FREQREF_RESET;
      irq_mask_q <= `OPIL_MASK_RESET;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        `OPIL_OFS_CTRL:     ctrl_q     <= hwdata;
        `OPIL_OFS_SRC:      src_q      <= hwdata;
        `OPIL_OFS_MINFREQ:  min_freq_q <= hwdata[15:0];
        `OPIL_OFS_FREQREF:  freq_ref_q <= hwdata[15:0];
        `OPIL_OFS_IRQ_MASK: irq_mask_q <= hwdata[6:0];
        default: ;
      endcase
    end
  end

  // Decoded drive inputs
  wire         remote    = ctrl_q[`OPIL_CTRL_REMOTE];
  wire         fault     = ctrl_q[`OPIL_CTRL_FAULT];
  wire         alarm     = ctrl_q[`OPIL_CTRL_ALARM];
  wire [1:0]   dstate    = ctrl_q[`OPIL_CTRL_DSTATE+:2];
  wire         running   = dstate == OPIL_DRV_RUNNING;
  wire         decel     = dstate == OPIL_DRV_DECEL;
  wire [2:0]   run_src   = src_q[2:0];
  wire [2:0]   ref_src   = src_q[10:8];
  wire         below_min = freq_ref_q < min_freq_q;

  // Stop key latches while running remotely; cleared once the drive leaves run or remote mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_key_q <= 1'b0;
    end else if (!running || !remote) begin
      stop_key_q <= 1'b0;
    end else if (ctrl_q[`OPIL_CTRL_STOPKEY]) begin
      stop_key_q <= 1'b1;
    end
  end

  opil_lamp_t m_fwd, m_rev, m_alm, m_seq, m_ref, m_run, m_stop;

  always_comb begin
    m_fwd = ctrl_q[`OPIL_CTRL_FWD] ? OPIL_LAMP_ON : OPIL_LAMP_OFF;
    m_rev = ctrl_q[`OPIL_CTRL_REV] ? OPIL_LAMP_ON : OPIL_LAMP_OFF;
    if (fault) m_alm = OPIL_LAMP_ON;
    else if (alarm) m_alm = OPIL_LAMP_BLINK;
    else m_alm = OPIL_LAMP_OFF;
    // Unknown codes above the listed ones leave the lamp off
    if (remote && run_src inside {OPIL_SRC_TERM, OPIL_SRC_COMM, OPIL_SRC_OPTION})
      m_seq = OPIL_LAMP_ON;
    else m_seq = OPIL_LAMP_OFF;
    if (remote && ref_src inside {OPIL_SRC_TERM, OPIL_SRC_COMM, OPIL_SRC_OPTION, OPIL_SRC_PULSE})
      m_ref = OPIL_LAMP_ON;
    else m_ref = OPIL_LAMP_OFF;
    if (running) m_run = OPIL_LAMP_ON;
    else if (decel) m_run = OPIL_LAMP_BLINK;
    else m_run = OPIL_LAMP_OFF;
    // Blink conditions take priority over the plain running case
    if (running && (below_min || stop_key_q)) m_stop = OPIL_LAMP_BLINK;
    else if (running) m_stop = OPIL_LAMP_OFF;
    else m_stop = OPIL_LAMP_ON;
  end

  opil_prescaler #(.HALF_CYCLES(BLINK_HALF_CYCLES)) u_pre (
    .hclk    (hclk),
    .hresetn (hresetn),
    .blink_q (blink)
  );

  opil_lamp_drv u_fwd (.hclk(hclk), .hresetn(hresetn), .mode(m_fwd), .blink(blink), .lamp_q(forward_lamp));
  opil_lamp_drv u_rev (.hclk(hclk), .hresetn(hresetn), .mode(m_rev), .blink(blink), .lamp_q(reverse_lamp));
  opil_lamp_drv u_alm (.hclk(hclk), .hresetn(hresetn), .mode(m_alm), .blink(blink), .lamp_q(alarm_lamp));
  opil_lamp_drv u_seq (.hclk(hclk), .hresetn(hresetn), .mode(m_seq), .blink(blink), .lamp_q(remote_sequence_lamp));
  opil_lamp_drv u_ref (.hclk(hclk), .hresetn(hresetn), .mode(m_ref), .blink(blink), .lamp_q(remote_reference_lamp));
  opil_lamp_drv u_run (.hclk(hclk), .hresetn(hresetn), .mode(m_run), .blink(blink), .lamp_q(run_lamp));
  opil_lamp_drv u_stp (.hclk(hclk), .hresetn(hresetn), .mode(m_stop), .blink(blink), .lamp_q(stop_lamp));

  assign lamps = {stop_lamp, run_lamp, remote_reference_lamp, remote_sequence_lamp,
                  alarm_lamp, reverse_lamp, forward_lamp};

  // Events: a lamp pin turning on; a read of the status clears it, a new event wins
  assign rd_stat = rd_req && (haddr == `OPIL_OFS_IRQ_STAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamps_prev_q <= 7'h00;
      irq_stat_q   <= 7'h00;
    end else begin
      lamps_prev_q <= lamps;
      irq_stat_q   <= (rd_stat ? 7'h00 : irq_stat_q) | (lamps & ~lamps_prev_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else irq <= |(irq_stat_q & irq_mask_q);
  end

  always_comb begin
    unique case (haddr)
      `OPIL_OFS_CTRL:     rdata_d = ctrl_q;
      `OPIL_OFS_SRC:      rdata_d = src_q;
      `OPIL_OFS_MINFREQ:  rdata_d = {16'h0000, min_freq_q};
      `OPIL_OFS_FREQREF:  rdata_d = {16'h0000, freq_ref_q};
      `OPIL_OFS_LAMPS:    rdata_d = {25'h0000000, lamps};
      `OPIL_OFS_IRQ_STAT: rdata_d = {25'h0000000, irq_stat_q};
      `OPIL_OFS_IRQ_MASK: rdata_d = {25'h0000000, irq_mask_q};
      default:            rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_req) hrdata <= rdata_d;
    end
  end

  // Checks
  // The edge that lifts reset still loads reset values, so a lamp that must be lit waits one edge more
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rst_seen_q <= 1'b0;
    else rst_seen_q <= 1'b1;
  end

  sequence s_key_remote_run;
    running && remote && ctrl_q[`OPIL_CTRL_STOPKEY];
  endsequence
  sequence s_still_remote_run;
    running && remote;
  endsequence

  property p_fwd;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_q[`OPIL_CTRL_FWD] |=> forward_lamp;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward lamp not lit");

  property p_rev;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_q[`OPIL_CTRL_REV] |=> reverse_lamp;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse lamp not lit");

  property p_alm;
    @(posedge hclk) disable iff (!hresetn)
      fault |=> alarm_lamp;
  endproperty
  a_alm: assert property (p_alm) else $error("alarm lamp not steady on fault");

  property p_alm_fl;
    @(posedge hclk) disable iff (!hresetn)
      (alarm && !fault) |=> (alarm_lamp == $past(blink));
  endproperty
  a_alm_fl: assert property (p_alm_fl) else $error("alarm lamp not flashing");

  property p_seq;
    @(posedge hclk) disable iff (!hresetn)
      !remote |=> !remote_sequence_lamp;
  endproperty
  a_seq: assert property (p_seq) else $error("sequence lamp lit in local");

  property p_seq_on;
    @(posedge hclk) disable iff (!hresetn)
      (remote && run_src >= 3'h1 && run_src <= 3'h3) |=> remote_sequence_lamp;
  endproperty
  a_seq_on: assert property (p_seq_on) else $error("sequence lamp off");

  property p_seq_kp;
    @(posedge hclk) disable iff (!hresetn)
      (run_src == 3'h0) |=> !remote_sequence_lamp;
  endproperty
  a_seq_kp: assert property (p_seq_kp) else $error("sequence lamp on for keypad");

  property p_ref;
    @(posedge hclk) disable iff (!hresetn)
      !remote |=> !remote_reference_lamp;
  endproperty
  a_ref: assert property (p_ref) else $error("reference lamp lit in local");

  property p_ref_on;
    @(posedge hclk) disable iff (!hresetn)
      (remote && ref_src >= 3'h1 && ref_src <= 3'h4) |=> remote_reference_lamp;
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference lamp off");

  property p_ref_kp;
    @(posedge hclk) disable iff (!hresetn)
      (ref_src == 3'h0) |=> !remote_reference_lamp;
  endproperty
  a_ref_kp: assert property (p_ref_kp) else $error("reference lamp on for keypad");

  property p_run;
    @(posedge hclk) disable iff (!hresetn)
      (dstate == 2'h0) |=> !run_lamp;
  endproperty
  a_run: assert property (p_run) else $error("run lamp on while stopped");

  property p_run_on;
    @(posedge hclk) disable iff (!hresetn)
      running |=> run_lamp;
  endproperty
  a_run_on: assert property (p_run_on) else $error("run lamp off while running");

  property p_run_bl;
    @(posedge hclk) disable iff (!hresetn)
      decel |=> (run_lamp == $past(blink));
  endproperty
  a_run_bl: assert property (p_run_bl) else $error("run lamp not blinking while decelerating");

  property p_stop;
    @(posedge hclk) disable iff (!hresetn)
      (rst_seen_q && !running) |=> stop_lamp;
  endproperty
  a_stop: assert property (p_stop) else $error("stop lamp off while stopped");

  property p_stop_off;
    @(posedge hclk) disable iff (!hresetn)
      (running && !below_min && !stop_key_q) |=> !stop_lamp;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop lamp on while running");

  property p_stop_bl;
    @(posedge hclk) disable iff (!hresetn)
      (running && below_min) |=> (stop_lamp == $past(blink));
  endproperty
  a_stop_bl: assert property (p_stop_bl) else $error("stop lamp not blinking");

  property p_stop_key;
    @(posedge hclk) disable iff (!hresetn)
      s_key_remote_run ##1 s_still_remote_run |=> (stop_lamp == $past(blink));
  endproperty
  a_stop_key: assert property (p_stop_key) else $error("stop lamp not blinking after stop key");
endmodule // opil_top

// >>> verif/tb_top.sv
// Self-checking bench for the operator panel lamp logic
`timescale 1ns/10ps
`include "opil_defines.svh"
`define TB_CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import opil_pkg::*;
  localparam int         HALF  = 4;
  localparam logic [6:0] FORWARD_LAMP   = 7'h01 << `OPIL_L_FWD;
  localparam logic [6:0] REVERSE_LAMP   = 7'h01 << `OPIL_L_REV;
  localparam logic [6:0] ALM   = 7'h01 << `OPIL_L_ALM;
  localparam logic [6:0] SEQ   = 7'h01 << `OPIL_L_SEQ;
  localparam logic [6:0] REF   = 7'h01 << `OPIL_L_REF;
  localparam logic [6:0] RUN   = 7'h01 << `OPIL_L_RUN;
  localparam logic [6:0] STP   = 7'h01 << `OPIL_L_STOP;
  localparam logic [5:0] RMT   = 6'h01;
  localparam logic [5:0] F_FWD = 6'h02;
  localparam logic [5:0] F_REV = 6'h04;
  localparam logic [5:0] FLT   = 6'h08;
  localparam logic [5:0] ALR   = 6'h10;
  localparam logic [5:0] SKEY  = 6'h20;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [11:0] haddr   = 12'h000;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  wire  [6:0]  lamps;
  logic [31:0] rd;
  int          fails   = 0;
  int          n_tests = 0;

  always #5 hclk = ~hclk;

  opil_top #(.BLINK_HALF_CYCLES(HALF)) opil_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .forward_lamp(lamps[0]), .reverse_lamp(lamps[1]), .alarm_lamp(lamps[2]),
    .remote_sequence_lamp(lamps[3]), .remote_reference_lamp(lamps[4]),
    .run_lamp(lamps[5]), .stop_lamp(lamps[6]), .irq(irq)
  );

  task automatic ahb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr_en;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `TB_CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    `TB_CHK(rd, e)
  endtask

  function automatic logic [31:0] ctl(input opil_drive_t st, input logic [5:0] f);
    ctl = (32'(st) << `OPIL_CTRL_DSTATE) | 32'(f);
  endfunction

  // Steady lamps must never change over a window longer than one blink period
  task automatic chk_lamps(input logic [6:0] on_m, input logic [6:0] bl_m);
    logic [6:0] s1;
    logic [6:0] s0;
    s1 = 7'h00;
    s0 = 7'h00;
    repeat (4) @(posedge hclk);
    repeat (12) begin
      @(negedge hclk);
      s1 = s1 | lamps;
      s0 = s0 | ~lamps;
    end
    `TB_CHK({s1, s0}, {on_m | bl_m, ~on_m | bl_m})
  endtask

  task automatic summarize();
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    logic [6:0] e;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`OPIL_OFS_CTRL, `OPIL_CTRL_RESET);
    rdchk(`OPIL_OFS_SRC, `OPIL_SRC_RESET);
    rdchk(`OPIL_OFS_MINFREQ, 32'(`OPIL_MINFREQ_RESET));
    rdchk(`OPIL_OFS_FREQREF, 32'(`OPIL_FREQREF_RESET));
    rdchk(`OPIL_OFS_IRQ_MASK, 32'(`OPIL_MASK_RESET));
    chk_lamps(STP, 7'h00);
    rdchk(`OPIL_OFS_LAMPS, 32'(STP));
    wr(`OPIL_OFS_LAMPS, 32'h0000_007f);
    rdchk(`OPIL_OFS_LAMPS, 32'(STP));
    wr(12'h100, 32'hdead_beef);
    rdchk(12'h100, 32'h0000_0000);
    // Reference equal to the minimum is not below it
    wr(`OPIL_OFS_MINFREQ, 32'h0000_0064);
    wr(`OPIL_OFS_FREQREF, 32'h0000_0064);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_RUNNING, F_FWD));
    chk_lamps(FORWARD_LAMP | RUN, 7'h00);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_RUNNING, F_REV));
    chk_lamps(REVERSE_LAMP | RUN, 7'h00);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_DECEL, F_REV));
    chk_lamps(REVERSE_LAMP | STP, RUN);
    wr(`OPIL_OFS_FREQREF, 32'h0000_0063);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_RUNNING, F_FWD));
    chk_lamps(FORWARD_LAMP | RUN, STP);
    wr(`OPIL_OFS_FREQREF, 32'h0000_0064);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_RUNNING, F_FWD | SKEY));
    chk_lamps(FORWARD_LAMP | RUN, 7'h00);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_RUNNING, F_FWD | SKEY | RMT));
    chk_lamps(FORWARD_LAMP | RUN, STP);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_RUNNING, F_FWD | RMT));
    chk_lamps(FORWARD_LAMP | RUN, STP);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_STOPPED, FLT));
    chk_lamps(ALM | STP, 7'h00);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_STOPPED, ALR));
    chk_lamps(STP, ALM);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_STOPPED, FLT | ALR));
    chk_lamps(ALM | STP, 7'h00);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_DECEL, ALR));
    chk_lamps(STP, ALM | RUN);
    repeat (12) begin
      @(negedge hclk);
      `TB_CHK(lamps[`OPIL_L_ALM], lamps[`OPIL_L_RUN])
    end
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        wr(`OPIL_OFS_SRC, (32'(c) << 8) | 32'(c));
        wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_STOPPED, 6'(r)));
        e = STP;
        if (r == 1 && c >= 1 && c <= 3)
          e = e | SEQ;
        if (r == 1 && c >= 1 && c <= 4)
          e = e | REF;
        chk_lamps(e, 7'h00);
      end
    end
    wr(`OPIL_OFS_SRC, 32'h0000_0000);
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_STOPPED, 6'h00));
    repeat (10) @(posedge hclk);
    ahb(1'b0, `OPIL_OFS_IRQ_STAT, 32'h0000_0000);
    wr(`OPIL_OFS_IRQ_MASK, 32'(FORWARD_LAMP));
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_RUNNING, F_FWD));
    repeat (6) @(posedge hclk);
    `TB_CHK(irq, 1'b1)
    rdchk(`OPIL_OFS_IRQ_STAT, 32'(FORWARD_LAMP | RUN));
    repeat (3) @(posedge hclk);
    `TB_CHK(irq, 1'b0)
    wr(`OPIL_OFS_CTRL, ctl(OPIL_DRV_RUNNING, F_REV));
    repeat (6) @(posedge hclk);
    `TB_CHK(irq, 1'b0)
    rdchk(`OPIL_OFS_IRQ_STAT, 32'(REVERSE_LAMP));
    rdchk(`OPIL_OFS_IRQ_STAT, 32'h0000_0000);
    summarize();
  end

  // Whole run is well under a thousand cycles; this limit leaves wide margin
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule // tb_top
